// [rtl/bit_test_skip_and_bit_set.sv]
// Purpose: Executes the bit test with skip on clear and the bit set instruction.
// Assumes: Register file read is combinational; one instruction per mclk cycle.
// Notes: Status flags are not touched; status_write_en stays low.
// Notes: A set writes one cycle late, so the register file keeps the address it saw with the set.
// Notes: A test of a byte written by the set just before it still reads the old value.
`timescale 1ns/10ps
module bit_test_skip_and_bit_set
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic insn_valid,
   input wire logic [bit_exec_pkg::INSN_W-1:0] insn_word,
   output logic [bit_exec_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [bit_exec_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_we,
   output logic [bit_exec_pkg::DATA_W-1:0] reg_wdata,
   output logic insn_done,
   output logic skip_taken,
   output logic flushing,
   output logic status_write_en
);
   import bit_exec_pkg::*;

   // Decoded view of the word executed this cycle.
   bit_decode_if dec_bus ();

   // Sequencing state: running, or discarding the word behind a taken skip.
   exec_state_t state_reg;
   exec_state_t state_next;

   // Write port state; the write leaves one cycle after the set is taken.
   logic we_reg;
   logic we_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;

   // Completion pulses, one cycle wide each.
   logic done_reg;
   logic done_next;
   logic skip_reg;
   logic skip_next;

   // Qualifiers of the current word, shared by all three groups below.
   logic in_flush;
   logic word_live;
   logic is_test;
   logic is_set;
   logic tested_bit;

   // Reads one bit of a byte; the index is decoded in one place for every user.
   function automatic logic bit_of
   (
      input logic [DATA_W-1:0] v,
      input logic [BIT_W-1:0] b
   );
      return v[b];
   endfunction : bit_of

   // Sets one bit of a byte; the other bits pass unchanged.
   function automatic logic [DATA_W-1:0] set_bit
   (
      input logic [DATA_W-1:0] v,
      input logic [BIT_W-1:0] b
   );
      logic [DATA_W-1:0] r;
      r = v;
      r[b] = 1'b1;
      return r;
   endfunction : set_bit

   // A word may act only when it is valid and is not the one behind a taken skip.
   function automatic logic accepts_word
   (
      input logic valid,
      input exec_state_t st
   );
      return valid && (st == ST_RUN);
   endfunction : accepts_word

   // The discarded word is swapped for a no-op before decoding, so no field of it can
   // reach the write port or the pulses; the state check in accepts_word is a second guard.
   assign dec_bus.insn = (state_reg == ST_FLUSH) ? INSN_NOP : insn_word;

   // The field split lives in its own module so both instructions share one layout.
   bit_decode u_decode
   (
      .dec(dec_bus)
   );

   // Qualifiers of the word on insn_word this cycle.
   assign in_flush = (state_reg == ST_FLUSH);
   assign word_live = accepts_word(insn_valid, state_reg);
   assign is_test = (dec_bus.op == OP_TEST_CLEAR);
   assign is_set = (dec_bus.op == OP_SET);
   assign tested_bit = bit_of(reg_rdata, dec_bus.bit_index);

   // The read address goes straight out so the register file answers within this cycle.
   // During a flush it shows address zero, since the no-op decode has all fields clear.
   assign reg_addr = dec_bus.addr;

   // No status flag is ever written by either instruction.
   assign status_write_en = 1'b0;
   assign flushing = in_flush;

   // Sequencing: a clear bit sends the following word into the flush.
   // The flush ends only with a valid word, so a fetch stall cannot let the dropped word through.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
         begin
            if (word_live && is_test && !tested_bit)
            begin
               state_next = ST_FLUSH;
            end
         end
         ST_FLUSH:
         begin
            if (insn_valid)
            begin
               state_next = ST_RUN;
            end
         end
         default:
         begin
            state_next = ST_RUN;
         end
      endcase
   end

   // Sequencing register.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_reg <= ST_RUN;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Write port: read, set one bit, write back. The write is registered to keep the output
   // clean, which costs a read-after-write hazard on a test right behind a set to the same byte.
   always_comb
   begin
      we_next = 1'b0;
      wdata_next = wdata_reg;
      if (word_live && is_set)
      begin
         we_next = 1'b1;
         wdata_next = set_bit(reg_rdata, dec_bus.bit_index);
      end
   end

   // Write port registers; the data holds its last value between writes.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         we_reg <= 1'b0;
         wdata_reg <= '0;
      end
      else
      begin
         we_reg <= we_next;
         wdata_reg <= wdata_next;
      end
   end

   // Completion pulses: a bit found set, a set, or the no-op of a taken skip finishes the
   // instruction; a bit found clear raises the skip pulse instead and finishes in the cycle after the next valid word.
   always_comb
   begin
      done_next = 1'b0;
      skip_next = 1'b0;
      case (state_reg)
         ST_RUN:
         begin
            if (word_live && is_test)
            begin
               if (tested_bit)
               begin
                  done_next = 1'b1;
               end
               else
               begin
                  skip_next = 1'b1;
               end
            end
            else if (word_live && is_set)
            begin
               done_next = 1'b1;
            end
         end
         ST_FLUSH:
         begin
            // The no-op takes the place of the dropped word and ends the two-cycle test.
            done_next = insn_valid;
         end
         default:
         begin
            done_next = 1'b0;
         end
      endcase
   end

   // Pulse registers.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         done_reg <= 1'b0;
         skip_reg <= 1'b0;
      end
      else
      begin
         done_reg <= done_next;
         skip_reg <= skip_next;
      end
   end

   // All data and pulse outputs come straight from flip-flops.
   assign reg_we = we_reg;
   assign reg_wdata = wdata_reg;
   assign insn_done = done_reg;
   assign skip_taken = skip_reg;
endmodule : bit_test_skip_and_bit_set

// [shared/bit_exec_pkg.sv]
// Purpose: Constants and types for the bit test and bit set execution block.
// Assumes: 14-bit instruction words, 7-bit register addresses, 8-bit registers.
// Notes: Contract list below.
// Contract
// - Test takes 7-bit address, 3-bit bit index.
// - Prefix 0110 skips next word on clear bit.
// - Skipped prefetched word never changes state.
// - Skip runs a no-op; two cycles, one word.
// - Prefix 0101 sets one bit, single cycle.
// - Set takes address and bit from low bits.
package bit_exec_pkg;
   localparam int INSN_W = 14;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int DATA_W = 8;
   localparam int ADDR_LSB = 0;
   localparam int BIT_LSB = 7;
   localparam int PREFIX_LSB = 10;
   localparam int PREFIX_W = 4;
   localparam logic [PREFIX_W-1:0] PREFIX_TEST_CLEAR = 4'h6;
   localparam logic [PREFIX_W-1:0] PREFIX_SET = 4'h5;
   localparam logic [INSN_W-1:0] INSN_NOP = 14'h0000;
   typedef enum logic [1:0] {OP_OTHER, OP_TEST_CLEAR, OP_SET} op_t;
   typedef enum logic {ST_RUN, ST_FLUSH} exec_state_t;
endpackage : bit_exec_pkg

// [shared/bit_decode_if.sv]
// Purpose: Carries decoded fields from the decoder to the execution logic.
// Assumes: One decoder and one consumer.
// Notes: Purely combinational fields.
`timescale 1ns/10ps
interface bit_decode_if;
   import bit_exec_pkg::*;
   logic [INSN_W-1:0] insn;
   op_t op;
   logic [ADDR_W-1:0] addr;
   logic [BIT_W-1:0] bit_index;
   modport decoder (input insn, output op, output addr, output bit_index);
   modport consumer (output insn, input op, input addr, input bit_index);
endinterface : bit_decode_if

// [rtl/bit_decode.sv]
// Purpose: Splits an instruction word into opcode class, address and bit index.
// Assumes: Both instructions share the same field layout.
// Notes: Any other prefix decodes as OP_OTHER and is left to the rest of the core.
`timescale 1ns/10ps
module bit_decode
   import bit_exec_pkg::*;
(
   bit_decode_if.decoder dec
);
   // Fields sit in the low bits of the word for both instructions.
   always_comb
   begin
      dec.addr = dec.insn[ADDR_LSB +: ADDR_W];
      dec.bit_index = dec.insn[BIT_LSB +: BIT_W];
      case (dec.insn[PREFIX_LSB +: PREFIX_W])
         PREFIX_TEST_CLEAR: dec.op = OP_TEST_CLEAR;
         PREFIX_SET: dec.op = OP_SET;
         default: dec.op = OP_OTHER;
      endcase
   end
endmodule : bit_decode

// [testbench/bit_test_skip_and_bit_set_checker.sv]
// Purpose: Assertions for the bit test and bit set block.
// Assumes: One clock, synchronous reset.
// Notes: Bound to the top module.
`timescale 1ns/10ps
module bit_test_skip_and_bit_set_checker
   import bit_exec_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic insn_valid,
   input wire logic [INSN_W-1:0] insn_word,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_we,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic insn_done,
   input wire logic skip_taken,
   input wire logic flushing,
   input wire logic status_write_en
);
   // A word that arrives while flushing must count for nothing.
   wire logic live = insn_valid && !flushing;
   wire logic bit_now = reg_rdata[insn_word[9:7]];
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   chk_addr_field: assert property (!flushing |-> reg_addr == insn_word[6:0])
      else $error("bad read address");
   chk_skip_clear: assert property (live && insn_word[13:10] == 4'h6 && !bit_now |=> skip_taken && flushing)
      else $error("skip missed");
   chk_no_skip: assert property (live && insn_word[13:10] == 4'h6 && bit_now |=> !skip_taken && insn_done)
      else $error("false skip");
   chk_flush_drop: assert property (flushing |=> !reg_we && !skip_taken)
      else $error("dropped word acted");
   chk_nop_cycle: assert property (flushing && insn_valid |=> insn_done && !flushing)
      else $error("no-op cycle wrong");
   chk_set_bit: assert property (live && insn_word[13:10] == 4'h5 |=> reg_we && insn_done &&
      reg_wdata == ($past(reg_rdata) | (8'h01 << $past(insn_word[9:7])))) else $error("bad set");
   chk_flags_kept: assert property (status_write_en == 1'b0)
      else $error("status written");
endmodule : bit_test_skip_and_bit_set_checker
bind bit_test_skip_and_bit_set bit_test_skip_and_bit_set_checker i_chk (.*);

// [testbench/bit_test_skip_and_bit_set_tb_top.sv]
// Purpose: Self-checking bench for the bit test and bit set block.
// Assumes: Read data is driven together with each word.
// Notes: Inputs change at the rising edge.
`timescale 1ns/10ps
module bit_test_skip_and_bit_set_tb_top;
   import bit_exec_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic insn_valid = 1'b0;
   logic [INSN_W-1:0] insn_word = '0;
   logic [DATA_W-1:0] reg_rdata = '0;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_we, insn_done, skip_taken, flushing, status_write_en;
   int error_cnt = 0;
   int samples_checked = 0;
   // A prefix that neither instruction owns; it must not write, finish, skip or flush.
   localparam logic [PREFIX_W-1:0] PREFIX_OTHER = 4'h4;
   // Clock of 8 ns.
   always #4 mclk = ~mclk;
   bit_test_skip_and_bit_set i_dut (.*);
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Sampling 1 ns late lets the edge's updates land first.
   task go(input logic [INSN_W-1:0] w, input logic [DATA_W-1:0] d, input logic v);
      @(posedge mclk);
      insn_valid <= v;
      insn_word <= w;
      reg_rdata <= d;
      #1;
   endtask : go
   task set_each_bit;
      for (int b = 0; b < 8; b++)
      begin
         go({PREFIX_SET, 3'(b), 7'h7F}, 8'h0A, 1'b1);
         check(16'(reg_addr), 16'(7'h7F));
         go(INSN_NOP, 8'h00, 1'b0);
         check(16'({reg_we, insn_done, reg_wdata}), 16'({2'h3, 8'h0A | (8'h01 << b)}));
      end
   endtask : set_each_bit
   // A set right behind a taken skip must be thrown away.
   task skip_then_drop;
      go({PREFIX_TEST_CLEAR, 3'h3, 7'h15}, 8'hF7, 1'b1);
      check(16'(reg_addr), 16'(7'h15));
      go({PREFIX_SET, 3'h0, 7'h15}, 8'h00, 1'b1);
      check(16'({skip_taken, flushing}), 16'(2'h3));
      go(INSN_NOP, 8'h00, 1'b0);
      check(16'({reg_we, skip_taken, flushing, insn_done}), 16'(4'h1));
   endtask : skip_then_drop
   task test_bit_one;
      go({PREFIX_TEST_CLEAR, 3'h7, 7'h00}, 8'h80, 1'b1);
      go(INSN_NOP, 8'h00, 1'b0);
      check(16'({skip_taken, flushing, insn_done, status_write_en}), 16'(4'h2));
   endtask : test_bit_one
   // A skip waits through invalid words, and a reset in mid-flush drops it.
   task flush_hold_and_reset;
      go({PREFIX_TEST_CLEAR, 3'h1, 7'h01}, 8'hFD, 1'b1);
      go(INSN_NOP, 8'h00, 1'b0);
      check(16'({skip_taken, flushing, insn_done}), 16'(3'h6));
      go({PREFIX_SET, 3'h0, 7'h01}, 8'h00, 1'b0);
      check(16'({flushing, reg_addr}), 16'({1'b1, 7'h00}));
      go(INSN_NOP, 8'h00, 1'b0);
      check(16'({reg_we, flushing, insn_done}), 16'(3'h2));
      @(posedge mclk);
      reset <= 1'b1;
      @(posedge mclk);
      reset <= 1'b0;
      #1;
      check(16'({reg_we, skip_taken, flushing, insn_done}), 16'(4'h0));
   endtask : flush_hold_and_reset
   // A word with a foreign prefix must neither write, finish nor skip.
   task other_prefix;
      go({PREFIX_OTHER, 3'h2, 7'h10}, 8'h00, 1'b1);
      check(16'(reg_addr), 16'(7'h10));
      go(INSN_NOP, 8'h00, 1'b0);
      check(16'({reg_we, insn_done, skip_taken, flushing}), 16'(4'h0));
   endtask : other_prefix
   task test_done;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Main sequence after a 16-cycle reset.
   initial
   begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      set_each_bit();
      skip_then_drop();
      test_bit_one();
      flush_hold_and_reset();
      other_prefix();
      test_done();
   end
   // Watchdog; the tests need well under 100 cycles.
   initial
   begin
      #2000;
      error_cnt++;
      test_done();
   end
endmodule : bit_test_skip_and_bit_set_tb_top
